// ==== inc/clk_ctl_defines.svh ====
`ifndef CLK_CTL_DEFINES_SVH
`define CLK_CTL_DEFINES_SVH

// ----------------------------------------
// Register map (word index, byte = 4 x index)
// ----------------------------------------
`define CCR_INDEX 16'h0f86
`define STAT_INDEX 16'h0f87
`define CCR_RESET 8'ha0

// ----------------------------------------
// Unlock key bytes
// ----------------------------------------
`define UNLOCK_KEY1 8'he7
`define UNLOCK_KEY2 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BIT_RC_EN 7
`define BIT_XTAL_EN 6
`define BIT_WDOG_EN 5
`define BIT_SYS_FDE 4
`define BIT_WD_FDE 3
`define SEL_HI 2
`define SEL_LO 0

// ----------------------------------------
// Source select codes
// ----------------------------------------
`define SEL_RC_FAST 3'h0
`define SEL_RC_SLOW 3'h1
`define SEL_XTAL 3'h2
`define SEL_WDOG 3'h3
`define SEL_EXT 3'h4

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_SYS_FAIL 0
`define ST_WD_FAIL 1
`define ST_FORCED 2
`define ST_GOT_FIRST 3
`define ST_UNLOCKED 4

// ----------------------------------------
// Detector limits
// ----------------------------------------
`define WD_FAIL_CYCLES 8004
`define PRIM_FAIL_WD_TICKS 10

`endif

// ==== inc/clk_ctl_pkg.sv ====
`default_nettype none
package clk_ctl_pkg;
    typedef enum logic [1:0] {LOCKED, GOT_FIRST, UNLOCKED} lock_state_e;
    typedef logic [2:0] clk_sel_t;
endpackage
`default_nettype wire

// ==== design/miss_edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module miss_edge_detect #(
    parameter int LIMIT = 8004,
    parameter int CW = $clog2(LIMIT + 1)
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic enable, // Detector armed
    input wire logic ref_step, // One step of the reference count
    input wire logic seen_edge, // Watched clock showed an edge
    output logic fail // One-cycle failure pulse
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (LIMIT < 2) begin : g_chk
        $error("miss_edge_detect: LIMIT must be at least 2");
    end

    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic fail_r;
    logic fail_nxt;

    // An edge restarts the wait; a full count of steps is a failure
    wire at_last = cnt_r == LAST;
    wire step = enable & ~seen_edge & ref_step;
    assign fail_nxt = step & at_last;
    assign cnt_nxt = (~enable | seen_edge | fail_nxt) ? '0 :
                     step ? cnt_r + ONE : cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            fail_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            fail_r <= fail_nxt;
        end
    end

    assign fail = fail_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fail_at_limit_a: assert property (
        fail |-> $past(cnt_r) == LAST && $past(step))
        else $error("failure flagged before the full count");

    edge_restart_a: assert property (
        enable && seen_edge |=> cnt_r == '0 && !fail)
        else $error("edge did not restart the wait");

endmodule

`default_nettype wire

// ==== design/clock_source_control_top.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_defines.svh"

// Function
// - E7H then 18H unlock; next write stores, relocks
// - Writes outside unlock order leave register unchanged
// - Other register traffic keeps unlock progress
// - Detect enables settable after successful select write
// - Source change never clears precision RC enable
// - Primary failure raises event, forces watchdog clock
// - No forced switch if watchdog selected/disabled
// - Primary failure below about 1 kHz
// - Watchdog failure raises event, keeps clock source
// - Watchdog failure stops primary failure detection
// - Watchdog failure after 8004 edgeless cycles
// - Register holds enables, detect enables, select
// - Select decode; codes above 100 reserved
// - Crystal enable takes crystal pins from GPIO

module clock_source_control_top #(
    parameter int ADDR_W = 16,
    parameter int WD_FAIL_CYCLES = `WD_FAIL_CYCLES,
    parameter int PRIM_FAIL_TICKS = `PRIM_FAIL_WD_TICKS
) (
    input wire logic pclk, // System clock, 25 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high = write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic wdog_osc_tick, // Watchdog osc edge, 1 cycle
    input wire logic prim_osc_tick, // Primary osc edge, 1 cycle
    output logic precision_rc_osc_enable, // Precision RC enable
    output logic crystal_osc_enable, // Crystal osc enable
    output logic watchdog_osc_enable, // Watchdog osc enable
    output logic crystal_pin_owner, // High: crystal owns its pins
    output logic [2:0] sysclk_source_select, // Clock mux select
    output logic sysclk_fail_event, // Primary failure pulse
    output logic watchdog_fail_event // Watchdog failure pulse
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (ADDR_W < 14 || ADDR_W > 32) begin : g_chk
        $error("clock_source_control_top: ADDR_W out of 14..32");
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic sel_reserved(
        input logic [2:0] s
    );
        return s > `SEL_EXT;
    endfunction

    localparam logic [ADDR_W-1:0] CCR_ADDR =
        ADDR_W'({`CCR_INDEX, 2'b00});
    localparam logic [ADDR_W-1:0] STAT_ADDR =
        ADDR_W'({`STAT_INDEX, 2'b00});
    localparam logic [7:0] CCR_RST = `CCR_RESET;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire hit_ccr = paddr == CCR_ADDR;
    wire hit_stat = paddr == STAT_ADDR;
    wire mapped = hit_ccr | hit_stat;
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_ccr = access_ph & pwrite & hit_ccr & pstrb[0];
    wire wr_stat = access_ph & pwrite & hit_stat & pstrb[0];
    wire [7:0] wbyte = pwdata[7:0];

    // Zero wait states: every access completes in its first cycle
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;

    // ----------------------------------------
    // Unlock tracker
    // ----------------------------------------
    clk_ctl_pkg::lock_state_e lock_r;
    clk_ctl_pkg::lock_state_e lock_nxt;

    // Only writes to the control word move it; all else leaves it
    always_comb begin
        lock_nxt = lock_r;
        if (wr_ccr) begin
            unique case (lock_r)
                clk_ctl_pkg::LOCKED: begin
                    if (wbyte == `UNLOCK_KEY1) begin
                        lock_nxt = clk_ctl_pkg::GOT_FIRST;
                    end
                end
                clk_ctl_pkg::GOT_FIRST: begin
                    if (wbyte == `UNLOCK_KEY2) begin
                        lock_nxt = clk_ctl_pkg::UNLOCKED;
                    end else begin
                        lock_nxt = clk_ctl_pkg::LOCKED;
                    end
                end
                clk_ctl_pkg::UNLOCKED: begin
                    lock_nxt = clk_ctl_pkg::LOCKED;
                end
            endcase
        end
    end

    wire wr_ok = wr_ccr & (lock_r == clk_ctl_pkg::UNLOCKED);

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] ccr_r;
    logic [7:0] ccr_nxt;

    // A reserved select code keeps the stored select in ccr_r; the other
    // fields still take the new value so enables are not lost
    wire [2:0] wsel = wbyte[`SEL_HI:`SEL_LO];
    wire [2:0] sel_keep = sel_reserved(wsel) ?
                          ccr_r[`SEL_HI:`SEL_LO] : wsel;
    // Enables ride on every accepted write, select or not
    assign ccr_nxt = wr_ok ? {wbyte[7:3], sel_keep} : ccr_r;

    wire [2:0] sel_req = ccr_r[`SEL_HI:`SEL_LO];
    wire wdog_en = ccr_r[`BIT_WDOG_EN];
    wire wdog_is_sys = sel_req == `SEL_WDOG;

    // ----------------------------------------
    // Failure detection
    // ----------------------------------------
    logic force_r;
    logic force_nxt;
    logic sys_flag_r;
    logic sys_flag_nxt;
    logic wd_flag_r;
    logic wd_flag_nxt;
    logic prim_fail;
    logic wdog_fail;

    // Primary check needs a live watchdog reference; once forced,
    // the watchdog is the clock and the check has nothing to watch
    wire prim_det_en = ccr_r[`BIT_SYS_FDE] & wdog_en & ~wdog_is_sys &
                       ~wd_flag_r & ~force_r;
    wire wd_det_en = ccr_r[`BIT_WD_FDE] & wdog_en & ~wdog_is_sys;

    miss_edge_detect #(
        .LIMIT(PRIM_FAIL_TICKS)
    ) u_prim_det (
        .pclk(pclk),
        .presetn(presetn),
        .enable(prim_det_en),
        .ref_step(wdog_osc_tick),
        .seen_edge(prim_osc_tick),
        .fail(prim_fail)
    );

    miss_edge_detect #(
        .LIMIT(WD_FAIL_CYCLES)
    ) u_wdog_det (
        .pclk(pclk),
        .presetn(presetn),
        .enable(wd_det_en),
        .ref_step(1'b1),
        .seen_edge(wdog_osc_tick),
        .fail(wdog_fail)
    );

    // Drop a report if its enable fell while the pulse was in flight
    wire prim_hit = prim_fail & prim_det_en;
    wire wd_hit = wdog_fail & wd_det_en;

    // A new failure wins over a clear in the same cycle
    assign force_nxt = prim_hit | (force_r & ~wr_ok);
    assign sys_flag_nxt = prim_hit |
        (sys_flag_r & ~(wr_stat & wbyte[`ST_SYS_FAIL]));
    assign wd_flag_nxt = wd_hit |
        (wd_flag_r & ~(wr_stat & wbyte[`ST_WD_FAIL]));

    wire [2:0] sel_eff_nxt = force_nxt ? `SEL_WDOG :
                             ccr_nxt[`SEL_HI:`SEL_LO];

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] status = {3'h0,
                         lock_r == clk_ctl_pkg::UNLOCKED,
                         lock_r == clk_ctl_pkg::GOT_FIRST,
                         force_r, wd_flag_r, sys_flag_r};
    wire [31:0] rd_word = hit_ccr ? {24'h00_0000, ccr_r} :
                          hit_stat ? {24'h00_0000, status} :
                          32'h0000_0000;
    // Captured in setup so prdata is a flop during the access cycle
    logic [31:0] prdata_r;
    wire [31:0] prdata_nxt = (setup_ph & ~pwrite) ? rd_word : prdata_r;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [2:0] sel_eff_r;
    logic sys_ev_r;
    logic wd_ev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= clk_ctl_pkg::LOCKED;
            ccr_r <= `CCR_RESET;
            force_r <= 1'b0;
            sys_flag_r <= 1'b0;
            wd_flag_r <= 1'b0;
            sel_eff_r <= `SEL_RC_FAST;
            sys_ev_r <= 1'b0;
            wd_ev_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            lock_r <= lock_nxt;
            ccr_r <= ccr_nxt;
            force_r <= force_nxt;
            sys_flag_r <= sys_flag_nxt;
            wd_flag_r <= wd_flag_nxt;
            sel_eff_r <= sel_eff_nxt;
            sys_ev_r <= prim_hit;
            wd_ev_r <= wd_hit;
            prdata_r <= prdata_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_r;
    // Bit only changes on an accepted write, never on a switch
    assign precision_rc_osc_enable = ccr_r[`BIT_RC_EN];
    assign crystal_osc_enable = ccr_r[`BIT_XTAL_EN];
    assign crystal_pin_owner = ccr_r[`BIT_XTAL_EN];
    assign watchdog_osc_enable = wdog_en;
    assign sysclk_source_select = sel_eff_r;
    assign sysclk_fail_event = sys_ev_r;
    assign watchdog_fail_event = wd_ev_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_key1;
        wr_ccr && lock_r == clk_ctl_pkg::LOCKED &&
        wbyte == `UNLOCK_KEY1;
    endsequence

    sequence s_key2;
        wr_ccr && lock_r == clk_ctl_pkg::GOT_FIRST &&
        wbyte == `UNLOCK_KEY2;
    endsequence

    sequence s_store;
        wr_ccr && lock_r == clk_ctl_pkg::UNLOCKED;
    endsequence

    property p_key1_step;
        s_key1 |=> lock_r == clk_ctl_pkg::GOT_FIRST;
    endproperty

    property p_key2_step;
        s_key2 |=> lock_r == clk_ctl_pkg::UNLOCKED;
    endproperty

    property p_store;
        s_store |=> lock_r == clk_ctl_pkg::LOCKED &&
            ccr_r[7:3] == $past(wbyte[7:3]);
    endproperty

    key1_step_a: assert property (p_key1_step)
        else $error("first key byte not accepted");

    key2_step_a: assert property (p_key2_step)
        else $error("second key byte did not unlock");

    store_relock_a: assert property (p_store)
        else $error("unlocked write not stored or not relocked");

    locked_keep_a: assert property (
        $changed(ccr_r) |-> $past(wr_ccr) &&
            $past(lock_r) == clk_ctl_pkg::UNLOCKED)
        else $error("control word changed while locked");

    bad_key_a: assert property (
        wr_ccr && lock_r == clk_ctl_pkg::GOT_FIRST &&
        wbyte != `UNLOCK_KEY2 |=> lock_r == clk_ctl_pkg::LOCKED)
        else $error("wrong key byte did not relock");

    other_keep_a: assert property (
        !wr_ccr |=> lock_r == $past(lock_r))
        else $error("unlock progress broken by other access");

    rc_keep_a: assert property (
        $changed(sysclk_source_select) && !$past(wr_ok) |->
            $stable(precision_rc_osc_enable))
        else $error("precision RC enable changed on a switch");

    fail_switch_a: assert property (
        prim_hit |=> sysclk_fail_event &&
            sysclk_source_select == `SEL_WDOG && force_r)
        else $error("primary failure did not force watchdog");

    no_switch_a: assert property (
        $rose(force_r) |-> $past(wdog_en) && !$past(wdog_is_sys))
        else $error("forced switch with watchdog unusable");

    wd_event_a: assert property (
        wd_hit && !prim_hit && !wr_ok |=> watchdog_fail_event &&
            $stable(sysclk_source_select))
        else $error("watchdog failure moved the clock source");

    wd_blocks_a: assert property (
        wd_flag_r |-> !prim_det_en ##1 !sysclk_fail_event)
        else $error("primary detection alive after watchdog fail");

    sel_legal_a: assert property (
        !sel_reserved(sysclk_source_select))
        else $error("reserved clock source selected");

endmodule

`default_nettype wire

// ==== tb/osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module osc_model #(
    parameter int WD_PERIOD = 5,
    parameter int PRIM_PERIOD = 2
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic wdog_en, // Watchdog osc enable from block
    input wire logic wdog_run, // Watchdog osc healthy
    input wire logic prim_run, // Primary osc healthy
    output logic wdog_osc_tick, // Watchdog edge pulse
    output logic prim_osc_tick // Primary edge pulse
);
    int wd_cnt;
    int pr_cnt;
    // A disabled or broken oscillator shows no edges at all
    wire logic wd_live = wdog_en && wdog_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= 0;
            pr_cnt <= 0;
            wdog_osc_tick <= 1'b0;
            prim_osc_tick <= 1'b0;
        end else begin
            wd_cnt <= wd_live ? (wd_cnt + 1) % WD_PERIOD : 0;
            wdog_osc_tick <= wd_live && (wd_cnt == WD_PERIOD - 1);
            pr_cnt <= prim_run ? (pr_cnt + 1) % PRIM_PERIOD : 0;
            prim_osc_tick <= prim_run && (pr_cnt == PRIM_PERIOD - 1);
        end
    end
endmodule

`default_nettype wire

// ==== tb/system_clock_select_and_fail_recovery_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_defines.svh"

module system_clock_select_and_fail_recovery_tb;
    localparam int WD = 20;
    localparam logic [15:0] CTRL_A = 16'(`CCR_INDEX * 4);
    localparam logic [15:0] STAT_A = 16'(`STAT_INDEX * 4);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic wdog_osc_tick, prim_osc_tick, wdog_run, prim_run;
    logic rc_en, xtal_en, wd_en, pin_own, sys_ev, wd_ev;
    logic [2:0] sel;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    bit seen;
    logic [31:0] rd;
    logic err;

    always #20 pclk = ~pclk;

    clock_source_control_top #(.ADDR_W(16), .WD_FAIL_CYCLES(WD),
        .PRIM_FAIL_TICKS(3)) i_clock_source_control_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_osc_tick(wdog_osc_tick), .prim_osc_tick(prim_osc_tick),
        .precision_rc_osc_enable(rc_en), .crystal_osc_enable(xtal_en),
        .watchdog_osc_enable(wd_en), .crystal_pin_owner(pin_own),
        .sysclk_source_select(sel), .sysclk_fail_event(sys_ev),
        .watchdog_fail_event(wd_ev));

    osc_model #(.WD_PERIOD(5), .PRIM_PERIOD(2)) i_osc_model (
        .pclk(pclk), .presetn(presetn), .wdog_en(wd_en),
        .wdog_run(wdog_run), .prim_run(prim_run),
        .wdog_osc_tick(wdog_osc_tick), .prim_osc_tick(prim_osc_tick));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("unexpected stall at %0t: seen %h expected %h",
                     $time, pready, 1'b1);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, e);
    endtask

    // Key bytes, then the payload write that relocks
    task automatic unlock_write(input logic [7:0] v);
        apb(1'b1, CTRL_A, `UNLOCK_KEY1);
        apb(1'b1, CTRL_A, `UNLOCK_KEY2);
        apb(1'b1, CTRL_A, v);
        @(negedge pclk);
    endtask

    // A missing required event is a timeout and ends the run
    task automatic wait_evt(input bit wd, input int bound, input bit must);
        seen = 0;
        n = 0;
        while (!seen && n < bound) begin
            @(posedge pclk);
            n++;
            seen = wd ? (wd_ev === 1'b1) : (sys_ev === 1'b1);
        end
        if (must && !seen) begin
            miscompares++;
            $display("unexpected timeout at %0t: seen %h expected %h",
                     $time, 1'b0, 1'b1);
            wrap_up();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        wdog_run = 1;
        prim_run = 1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(32'({rc_en, xtal_en, wd_en, pin_own, 1'b0, sel}),
              32'h0000_00a0);
        rdc(CTRL_A, 32'h0000_00a0);
        apb(1'b1, CTRL_A, 8'h55);
        rdc(CTRL_A, 32'h0000_00a0);
        // A key byte without its low strobe is no unlock step
        pstrb <= 4'he;
        apb(1'b1, CTRL_A, `UNLOCK_KEY1);
        pstrb <= 4'hf;
        rdc(STAT_A, 32'h0000_0000);
        // Other traffic between the key bytes
        apb(1'b1, CTRL_A, `UNLOCK_KEY1);
        rdc(STAT_A, 32'h0000_0008);
        apb(1'b1, STAT_A, 8'h00);
        apb(1'b1, CTRL_A, `UNLOCK_KEY2);
        apb(1'b1, CTRL_A, 8'ha1);
        rdc(CTRL_A, 32'h0000_00a1);
        apb(1'b1, CTRL_A, 8'ha2);
        rdc(CTRL_A, 32'h0000_00a1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, CTRL_A, `UNLOCK_KEY1);
            apb(1'b1, CTRL_A, i == 0 ? 8'h33 : 8'he7);
            apb(1'b1, CTRL_A, `UNLOCK_KEY2);
            apb(1'b1, CTRL_A, 8'ha2);
            rdc(CTRL_A, 32'h0000_00a1);
        end
        // Every select code; reserved ones keep the select
        for (int c = 0; c < 8; c++) begin
            unlock_write(8'ha0 | 8'(c));
            check(32'(sel), 32'(c < 5 ? c : 4));
            check(32'(rc_en), 32'h0000_0001);
            rdc(CTRL_A, 32'h0000_00a0 | 32'(c < 5 ? c : 4));
        end
        unlock_write(8'he0);
        check(32'({xtal_en, pin_own}), 32'h0000_0003);
        repeat (1000) @(posedge pclk);
        unlock_write(8'he2);
        check(32'(sel), 32'h0000_0002);
        unlock_write(8'ha0);
        check(32'(pin_own), 32'h0000_0000);
        // Primary clock failure and forced fallback
        unlock_write(8'hb0);
        wait_evt(0, 30, 0);
        check(32'(seen), 32'h0000_0000);
        prim_run <= 1'b0;
        wait_evt(0, 40, 1);
        @(negedge pclk);
        check(32'(sel), 32'h0000_0003);
        rdc(STAT_A, 32'h0000_0005);
        prim_run <= 1'b1;
        apb(1'b1, STAT_A, 8'h03);
        unlock_write(8'ha0);
        check(32'(sel), 32'h0000_0000);
        rdc(STAT_A, 32'h0000_0000);
        // No fallback with watchdog selected or disabled
        for (int i = 0; i < 2; i++) begin
            unlock_write(i == 0 ? 8'hb3 : 8'h90);
            prim_run <= 1'b0;
            wait_evt(0, 40, 0);
            check(32'(seen), 32'h0000_0000);
            prim_run <= 1'b1;
            unlock_write(8'ha0);
        end
        // Watchdog failure, then primary detection is gone
        repeat (10) @(posedge pclk);
        unlock_write(8'hb8);
        wdog_run <= 1'b0;
        wait_evt(1, WD + 10, 1);
        check(32'(n >= WD - 6 && n <= WD + 3), 32'h0000_0001);
        @(negedge pclk);
        check(32'(sel), 32'h0000_0000);
        rdc(STAT_A, 32'h0000_0002);
        wdog_run <= 1'b1;
        prim_run <= 1'b0;
        wait_evt(0, 40, 0);
        check(32'(seen), 32'h0000_0000);
        prim_run <= 1'b1;
        apb(1'b1, STAT_A, 8'h03);
        unlock_write(8'ha0);
        rdc(STAT_A, 32'h0000_0000);
        // Unmapped address
        apb(1'b0, 16'h0000, 8'h00);
        check({rd[30:0], err}, 32'h0000_0001);
        wrap_up();
    end
endmodule

`default_nettype wire
